// file: design/eifl_pkg.sv
// Shared constants and carrier types for the external-interruption failure logic
package eifl_pkg;

    // ***************************************
    // Register port
    // ***************************************
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
    localparam logic [ADDR_W-1:0] CONFIG_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] FRR_OFS    = 8'h08;
    localparam logic [ADDR_W-1:0] FRM_OFS    = 8'h0c;
    localparam logic [ADDR_W-1:0] OLDPSW_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] PEND_OFS   = 8'h14;

    // ***************************************
    // Interruption code layout
    // ***************************************
    localparam int unsigned CODE_W       = 12;
    localparam int unsigned CODE_PSW_LSB = 20;
    localparam int unsigned NUM_DIRECT   = 8;
    localparam int unsigned PIR_W        = 3;
    localparam int unsigned PAIR_BITS    = 6;
    localparam int unsigned NORMAL_W     = NUM_DIRECT + 2;

    // ***************************************
    // Element states and reset values
    // ***************************************
    localparam logic [1:0] STATE_ZERO  = 2'h0;
    localparam logic [1:0] STATE_THREE = 2'h3;
    localparam logic [3:0] CTRL_RESET  = 4'h0;
    localparam logic [18:0] CFG_RESET  = 19'h00000;
    localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;

    typedef struct packed {
        logic       test_switch;
        logic [1:0] elem_state;
        logic       ext_mask;
    } eifl_ctrl_type;

    typedef struct packed {
        logic [PIR_W-1:0]      io_accept;
        logic [7:0]            set_configuration_instruction_accept;
        logic [NUM_DIRECT-1:0] direct_accept;
    } eifl_config_type;

    // Index k of the code is status word bit 20+k
    typedef struct packed {
        logic                  frr_ind;
        logic                  io_processor_interrupt_register;
        logic                  timer;
        logic                  key;
        logic [NUM_DIRECT-1:0] direct;
    } eifl_code_type;

endpackage : eifl_pkg

// file: design/eifl_top.sv
// External-interruption logic with failure request register and masks
//
// Operation
// RULE1: Taken interruption records 12-bit source code
// RULE2: Normal interruptions leave failure indicator clear
// RULE3: Mask bit 7 clear holds everything pending
// RULE4: Configured element check forces interrupt past mask
// RULE5: Forced element checks ignore failure mask bits
// RULE6: Many pending failures yield a single interruption
// RULE7: Each request bit is a single sticky flag
// RULE8: Direct communication bits gated by configuration, test
// RULE9: Key and timer bits set regardless of configuration
// RULE10: Code bit 30 from gated three-position register
// RULE11: Failure request sets its element's bit
// RULE12: Unmasked set bit with bit 7 interrupts
// RULE13: Failure indicator set when interruption taken
// RULE14: Diagnose read returns whole register, clears it
// RULE15: Pulse source stays cleared until recurring
// RULE16: Level source sets again after each read
// RULE17: No new sets land during the read
// RULE18: Failure mask written only by diagnose write
// RULE19: Zero mask bit blocks request except forced checks
// RULE20: Encoded element pairs share one even mask bit
// RULE21: Width, assignments, pulse or level are parameters
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
module eifl_top
    import eifl_pkg::*;
#(
    parameter int unsigned     FRR_W         = 16,
    parameter int unsigned     ELC_BASE      = 6,
    parameter int unsigned     NUM_CE        = 4,
    parameter logic [31:0]     FRR_LEVEL_SRC = 32'h0000_0000
) (
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wr_data_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rd_data_o,
    input  wire logic [NUM_DIRECT-1:0] direct_req_i,
    input  wire logic              key_req_i,
    input  wire logic              timer_req_i,
    input  wire logic [PIR_W-1:0]  pir_req_i,
    input  wire logic [FRR_W-1:0]  fail_req_i,
    input  wire logic              instr_done_i,
    output logic                   ext_int_take_o,
    output logic      [CODE_W-1:0] old_psw_code_o
);

    // ***************************************
    // Elaboration checks
    // ***************************************
    if (FRR_W < PAIR_BITS || FRR_W > DATA_W) begin : g_bad_width
        $error("failure register width out of range");
    end
    if (ELC_BASE < PAIR_BITS || ELC_BASE + NUM_CE > FRR_W || NUM_CE > 8 || NUM_CE < 1) begin : g_bad_elc
        $error("element check positions do not fit");
    end

    localparam int unsigned ASYNC_W = FRR_W + PIR_W + 2 + NUM_DIRECT;
    localparam logic [FRR_W-1:0] LVL_MASK = FRR_LEVEL_SRC[FRR_W-1:0];

    // ***************************************
    // Input synchronisers
    // ***************************************
    logic [ASYNC_W-1:0] async_in;
    logic [ASYNC_W-1:0] sync_a;
    logic [ASYNC_W-1:0] sync_b;
    logic [ASYNC_W-1:0] sync_prev;
    wire  [ASYNC_W-1:0] sync_rise = sync_b & ~sync_prev;

    assign async_in = {fail_req_i, pir_req_i, timer_req_i, key_req_i, direct_req_i};

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync_a    <= '0;
            sync_b    <= '0;
            sync_prev <= '0;
        end else begin
            sync_a    <= async_in;
            sync_b    <= sync_a;
            sync_prev <= sync_b;
        end
    end

    wire [NUM_DIRECT-1:0] direct_rise = sync_rise[NUM_DIRECT-1:0];
    wire                  key_rise    = sync_rise[NUM_DIRECT];
    wire                  timer_rise  = sync_rise[NUM_DIRECT+1];
    wire [PIR_W-1:0]      pir_rise    = sync_rise[NUM_DIRECT+2 +: PIR_W];
    wire [FRR_W-1:0]      fail_level  = sync_b[ASYNC_W-1 -: FRR_W];
    wire [FRR_W-1:0]      fail_rise   = sync_rise[ASYNC_W-1 -: FRR_W];

    // ***************************************
    // Software registers
    // ***************************************
    eifl_ctrl_type   ctrl;
    eifl_config_type cfg;
    logic [FRR_W-1:0] frm;

    wire wr_ctrl  = wr_i && addr_i == CTRL_OFS;
    wire wr_cfg   = wr_i && addr_i == CONFIG_OFS;
    wire wr_frm   = wr_i && addr_i == FRM_OFS;
    wire frr_rd   = rd_i && addr_i == FRR_OFS;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl <= eifl_ctrl_type'(CTRL_RESET);
            cfg  <= eifl_config_type'(CFG_RESET);
            frm  <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl <= eifl_ctrl_type'(wr_data_i[3:0]);
            end
            if (wr_cfg) begin
                cfg <= eifl_config_type'(wr_data_i[18:0]);
            end
            if (wr_frm) begin
                frm <= wr_data_i[FRR_W-1:0];  // see RULE18
            end
        end
    end

    // Element check forcing outside state three, zero only with test off
    wire forced_state = ctrl.elem_state != STATE_THREE &&
                        !(ctrl.elem_state == STATE_ZERO && ctrl.test_switch);  // see RULE4

    // ***************************************
    // Failure request register
    // ***************************************
    logic [FRR_W-1:0] frr;
    logic [FRR_W-1:0] frr_held;
    logic [FRR_W-1:0] frr_set;
    logic [FRR_W-1:0] eff_mask;
    logic [FRR_W-1:0] elc_force;
    logic             frr_taken;

    for (genvar i = 0; i < FRR_W; i++) begin : g_frr
        // Level sources keep setting; pulse sources only on a new edge
        assign frr_set[i] = FRR_LEVEL_SRC[i] ? fail_level[i] : fail_rise[i];  // see RULE15 see RULE16 see RULE21
        if (i < PAIR_BITS) begin : g_pair
            assign eff_mask[i] = frm[(i / 2) * 2];  // see RULE20
        end else begin : g_single
            assign eff_mask[i] = frm[i];  // see RULE19
        end
        if (i >= ELC_BASE && i < ELC_BASE + NUM_CE) begin : g_elc
            assign elc_force[i] = frr[i] & cfg.set_configuration_instruction_accept[i - ELC_BASE] & forced_state;  // see RULE5
        end else begin : g_no_elc
            assign elc_force[i] = 1'b0;
        end
    end

    // Sets that meet a read are held back one cycle instead of lost
    wire [FRR_W-1:0] next_frr      = frr_rd ? '0 : (frr | frr_set | frr_held);  // see RULE7 see RULE11 see RULE14
    wire [FRR_W-1:0] next_frr_held = frr_rd ? (frr_set | frr_held) : '0;  // see RULE17
    wire             frr_new       = |((frr_set | frr_held) & ~frr);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            frr      <= '0;
            frr_held <= '0;
        end else begin
            frr      <= next_frr;
            frr_held <= next_frr_held;
        end
    end

    // One interruption covers all bits set so far; a new bit or a read re-arms
    wire frr_req    = |(frr & eff_mask) && !frr_taken;  // see RULE6 see RULE19
    wire forced_req = |elc_force && !frr_taken;  // see RULE4

    // ***************************************
    // Normal interruption sources
    // ***************************************
    logic [NORMAL_W-1:0] pend;
    logic [PIR_W-1:0]    pir_reg;
    logic                take;

    wire [NUM_DIRECT-1:0] direct_set = direct_rise & cfg.direct_accept &
                                       {NUM_DIRECT{!ctrl.test_switch}};  // see RULE8
    wire [NORMAL_W-1:0]   pend_set   = {timer_rise, key_rise, direct_set};  // see RULE9
    wire [PIR_W-1:0]      pir_set    = pir_rise & cfg.io_accept;  // see RULE10
    wire                  pir_any    = |pir_reg;
    wire                  normal_any = |pend || pir_any;

    // A forced check under a closed mask must not consume normal requests
    wire                take_normal  = take && ctrl.ext_mask;  // see RULE3
    // Arrivals in the take cycle survive the clear
    wire [NORMAL_W-1:0] next_pend    = (take_normal ? '0 : pend) | pend_set;
    wire [PIR_W-1:0]    next_pir_reg = (take_normal ? '0 : pir_reg) | pir_set;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pend    <= '0;
            pir_reg <= '0;
        end else begin
            pend    <= next_pend;
            pir_reg <= next_pir_reg;
        end
    end

    // ***************************************
    // Taking the interruption
    // ***************************************
    assign take = instr_done_i &&
                  ((ctrl.ext_mask && (normal_any || frr_req)) || forced_req);  // see RULE3 see RULE12

    eifl_code_type take_code;
    assign take_code.frr_ind = frr_req || forced_req;  // see RULE2 see RULE13
    assign take_code.io_processor_interrupt_register     = pir_any && ctrl.ext_mask;
    assign take_code.timer   = pend[NUM_DIRECT+1] && ctrl.ext_mask;
    assign take_code.key     = pend[NUM_DIRECT] && ctrl.ext_mask;
    assign take_code.direct  = pend[NUM_DIRECT-1:0] & {NUM_DIRECT{ctrl.ext_mask}};

    wire next_frr_taken = (take && take_code.frr_ind) ? 1'b1 :
                          (frr_rd || frr_new)         ? 1'b0 : frr_taken;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            frr_taken      <= 1'b0;
            ext_int_take_o <= 1'b0;
            old_psw_code_o <= CODE_RESET;
        end else begin
            frr_taken      <= next_frr_taken;
            ext_int_take_o <= take;
            if (take) begin
                old_psw_code_o <= take_code;  // see RULE1
            end
        end
    end

    // ***************************************
    // Read data
    // ***************************************
    wire [DATA_W-1:0] next_rd_data =
        !rd_i                  ? '0 :
        addr_i == CTRL_OFS     ? DATA_W'(ctrl) :
        addr_i == CONFIG_OFS   ? DATA_W'(cfg) :
        addr_i == FRR_OFS      ? DATA_W'(frr) :
        addr_i == OLDPSW_OFS   ? DATA_W'(old_psw_code_o) :
        addr_i == PEND_OFS     ? DATA_W'({frr_taken, pir_reg, pend}) : '0;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= next_rd_data;
        end
    end

    // ***************************************
    // Assertions
    // ***************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_read;
        frr_rd;
    endsequence

    sequence s_idle_after;
        !frr_rd;
    endsequence

    property p_code_capture;
        take |=> ext_int_take_o && old_psw_code_o == $past(take_code);
    endproperty
    a_code_capture: assert property (p_code_capture) else $error("source code not captured");  // see RULE1

    property p_normal_no_ind;
        take && !frr_req && !forced_req |=> !old_psw_code_o[CODE_W-1];
    endproperty
    a_normal_no_ind: assert property (p_normal_no_ind) else $error("indicator set on normal take");  // see RULE2

    property p_mask_holds;
        !ctrl.ext_mask && !forced_req && normal_any |-> !take ##1 normal_any;
    endproperty
    a_mask_holds: assert property (p_mask_holds) else $error("masked request not held");  // see RULE3

    property p_forced;
        instr_done_i && forced_req |-> take ##1 old_psw_code_o[CODE_W-1];
    endproperty
    a_forced: assert property (p_forced) else $error("element check not forced");  // see RULE4

    property p_unmasked_take;
        instr_done_i && ctrl.ext_mask && frr_req |-> take ##1 ext_int_take_o;
    endproperty
    a_unmasked_take: assert property (p_unmasked_take) else $error("unmasked request not taken");  // see RULE12

    property p_single_take;
        take && take_code.frr_ind && !frr_rd && !frr_new |=> !frr_req && !forced_req;
    endproperty
    a_single_take: assert property (p_single_take) else $error("second take for same failures");  // see RULE6

    property p_sticky;
        (|frr_set) && !frr_rd |=> (frr & $past(frr_set)) == $past(frr_set);
    endproperty
    a_sticky: assert property (p_sticky) else $error("request bit not latched");  // see RULE11

    property p_read_clear;
        s_read |=> frr == '0 && rd_data_o == DATA_W'($past(frr));
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("diagnose read wrong");  // see RULE14

    property p_held_applied;
        s_read ##1 s_idle_after |=> (frr & $past(frr_held)) == $past(frr_held);
    endproperty
    a_held_applied: assert property (p_held_applied) else $error("held set lost after read");  // see RULE17

    property p_test_blocks;
        ctrl.test_switch |=> (pend[NUM_DIRECT-1:0] & ~$past(pend[NUM_DIRECT-1:0])) == '0;
    endproperty
    a_test_blocks: assert property (p_test_blocks) else $error("direct request set in test");  // see RULE8

    property p_mask_write;
        !wr_frm |=> $stable(frm);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask changed without write");  // see RULE18

    property p_forced_keeps;
        take && !ctrl.ext_mask |=> (pend & $past(pend)) == $past(pend) && (pir_reg & $past(pir_reg)) == $past(pir_reg);
    endproperty
    a_forced_keeps: assert property (p_forced_keeps) else $error("forced take consumed masked request");  // see RULE3

    property p_elc_unmaskable;
        instr_done_i && forced_state && !frr_taken && (frr[ELC_BASE +: NUM_CE] & cfg.set_configuration_instruction_accept[NUM_CE-1:0]) != '0 |-> take;
    endproperty
    a_elc_unmaskable: assert property (p_elc_unmaskable) else $error("element check was masked");  // see RULE5

    property p_sticky_hold;
        !frr_rd |=> (frr & $past(frr)) == $past(frr);
    endproperty
    a_sticky_hold: assert property (p_sticky_hold) else $error("request bit dropped without read");  // see RULE7

    property p_key_set;
        key_rise |=> pend[NUM_DIRECT];
    endproperty
    a_key_set: assert property (p_key_set) else $error("key request not recorded");  // see RULE9

    property p_timer_set;
        timer_rise |=> pend[NUM_DIRECT+1];
    endproperty
    a_timer_set: assert property (p_timer_set) else $error("timer request not recorded");  // see RULE9

    property p_pir_gate;
        !take_normal |=> pir_reg == ($past(pir_reg) | ($past(pir_rise) & $past(cfg.io_accept)));
    endproperty
    a_pir_gate: assert property (p_pir_gate) else $error("processor request gating wrong");  // see RULE10

    property p_code30;
        take_normal |=> old_psw_code_o[NUM_DIRECT+2] == $past(pir_any);
    endproperty
    a_code30: assert property (p_code30) else $error("processor code bit wrong");  // see RULE10

    property p_ind_on_take;
        take && (frr_req || forced_req) |=> old_psw_code_o[CODE_W-1];
    endproperty
    a_ind_on_take: assert property (p_ind_on_take) else $error("failure indicator missing");  // see RULE13

    property p_pulse_clear;
        !frr_rd |=> (frr & ~$past(frr) & ~$past(frr_set | frr_held)) == '0;
    endproperty
    a_pulse_clear: assert property (p_pulse_clear) else $error("request bit set without cause");  // see RULE15

    property p_level_reset;
        s_read ##1 s_idle_after |=> (frr & LVL_MASK & $past(fail_level, 2)) == (LVL_MASK & $past(fail_level, 2));
    endproperty
    a_level_reset: assert property (p_level_reset) else $error("level source not set again");  // see RULE16

    property p_zero_mask;
        take && !forced_req && (frr & eff_mask) == '0 |=> !old_psw_code_o[CODE_W-1];
    endproperty
    a_zero_mask: assert property (p_zero_mask) else $error("masked bit raised indicator");  // see RULE19

    property p_pair_mask;
        eff_mask[PAIR_BITS-1:0] == {{2{frm[4]}}, {2{frm[2]}}, {2{frm[0]}}};
    endproperty
    a_pair_mask: assert property (p_pair_mask) else $error("pair mask mapping wrong");  // see RULE20

endmodule : eifl_top

// file: test/eifl_far_model.sv
// Far-side model: other elements driving the request and failure lines
`timescale 1ns/100ps
module eifl_far_model
    import eifl_pkg::*;
#(
    parameter int unsigned FRR_W = 16
) (
    input  wire logic                  clk_i,
    output logic      [NUM_DIRECT-1:0] direct_req_o,
    output logic                       key_req_o,
    output logic                       timer_req_o,
    output logic      [PIR_W-1:0]      pir_req_o,
    output logic      [FRR_W-1:0]      fail_req_o
);
    initial begin
        {pir_req_o, timer_req_o, key_req_o, direct_req_o} = '0;
        fail_req_o = '0;
    end

    // Two-cycle pulses so the edge survives the input synchronisers
    task automatic fire(input logic [12:0] src, input logic [FRR_W-1:0] fail);
        @(posedge clk_i);
        {pir_req_o, timer_req_o, key_req_o, direct_req_o} <= src;
        fail_req_o <= fail_req_o | fail;
        repeat (2) @(posedge clk_i);
        {pir_req_o, timer_req_o, key_req_o, direct_req_o} <= '0;
        fail_req_o <= fail_req_o & ~fail;
    endtask : fire

    task automatic hold_fail(input int idx, input logic lvl);
        @(posedge clk_i);
        fail_req_o[idx] <= lvl;
    endtask : hold_fail
endmodule : eifl_far_model

// file: test/eifl_top_tb_top.sv
// Self-checking bench for the external-interruption failure logic
`timescale 1ns/100ps
module eifl_top_tb_top;
    import eifl_pkg::*;
    localparam int unsigned FRR_W = 16;
    typedef struct packed {
        logic [3:0]  ctrl;
        logic [18:0] cfg;
        logic [12:0] src;
        logic [13:0] pend;
        logic [11:0] code;
    } eifl_row_type;
    logic                  clk_i, reset_n_i, wr_i, rd_i, instr_done_i, ext_int_take_o;
    logic [ADDR_W-1:0]     addr_i;
    logic [DATA_W-1:0]     wr_data_i, rd_data_o, d;
    logic [NUM_DIRECT-1:0] direct_req_i;
    logic                  key_req_i, timer_req_i;
    logic [PIR_W-1:0]      pir_req_i;
    logic [FRR_W-1:0]      fail_req_i;
    logic [CODE_W-1:0]     old_psw_code_o;
    int                    fail_count, cmp_count, cycles;
    // Code 0 in a row means no interruption is expected
    eifl_row_type rows[8] = '{
        '{4'h1, 19'h0, 13'h0100, 14'h0100, 12'h100},
        '{4'h1, 19'h0, 13'h0200, 14'h0200, 12'h200},
        '{4'h1, 19'h8, 13'h0008, 14'h0008, 12'h008},
        '{4'h1, 19'h0, 13'h0080, 14'h0000, 12'h000},
        '{4'h9, 19'h8, 13'h0008, 14'h0000, 12'h000},
        '{4'h1, 19'h20000, 13'h0800, 14'h0800, 12'h400},
        '{4'h1, 19'h0, 13'h0800, 14'h0000, 12'h000},
        '{4'h1, 19'h0, 13'h0300, 14'h0300, 12'h300}};
    logic [3:0]  fc_ctrl[4] = '{4'h4, 4'h6, 4'h4, 4'h8};
    logic [18:0] fc_cfg[4]  = '{19'h100, 19'h100, 19'h0, 19'h100};
    logic [11:0] fc_code[4] = '{12'h800, 12'h000, 12'h000, 12'h000};

    eifl_top #(.FRR_W(FRR_W), .FRR_LEVEL_SRC(32'h0000_8000)) eifl_top_inst (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .direct_req_i(direct_req_i),
        .key_req_i(key_req_i), .timer_req_i(timer_req_i), .pir_req_i(pir_req_i),
        .fail_req_i(fail_req_i), .instr_done_i(instr_done_i),
        .ext_int_take_o(ext_int_take_o), .old_psw_code_o(old_psw_code_o));
    eifl_far_model #(.FRR_W(FRR_W)) eifl_far_model_inst (
        .clk_i(clk_i), .direct_req_o(direct_req_i), .key_req_o(key_req_i),
        .timer_req_o(timer_req_i), .pir_req_o(pir_req_i), .fail_req_o(fail_req_i));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // ***************************************
    // Checking and bus tasks
    // ***************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wr_data_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rd_data_o;
    endtask : rd

    task automatic take(input logic [11:0] code);
        @(posedge clk_i);
        instr_done_i <= 1'b1;
        @(posedge clk_i);
        instr_done_i <= 1'b0;
        #1 check("take", 32'(ext_int_take_o), 32'(code != 12'h0));
        if (code != 12'h0) check("code", 32'(old_psw_code_o), 32'(code));
    endtask : take

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            give_verdict();
        end
    end

    // ***************************************
    // Main sequence
    // ***************************************
    initial begin
        {addr_i, wr_data_i, wr_i, rd_i, instr_done_i} = '0;
        reset_n_i = 1'b0;
        repeat (8) @(posedge clk_i);
        #1 check("rst_out", {rd_data_o[19:0], old_psw_code_o}, 32'h0);
        check("rst_take", 32'(ext_int_take_o), 32'h0);
        reset_n_i <= 1'b1;
        rd(CTRL_OFS, d); check("ctrl_rst", d, 32'h0);
        rd(CONFIG_OFS, d); check("cfg_rst", d, 32'h0);
        wr(FRM_OFS, 32'hffff); rd(FRM_OFS, d); check("frm_rd", d, 32'h0);
        rd(8'h40, d); check("unmapped", d, 32'h0);
        foreach (rows[i]) begin
            wr(CONFIG_OFS, 32'(rows[i].cfg));
            wr(CTRL_OFS, 32'(rows[i].ctrl));
            eifl_far_model_inst.fire(rows[i].src, '0);
            repeat (6) @(posedge clk_i);
            rd(PEND_OFS, d); check("pend", d, 32'(rows[i].pend));
            take(rows[i].code);
            rd(PEND_OFS, d); check("pend_clr", d, 32'h0);
        end
        // Held while status mask is off, taken once it opens
        wr(CTRL_OFS, 32'h0); eifl_far_model_inst.fire(13'h100, '0);
        repeat (6) @(posedge clk_i);
        take(12'h000);
        wr(CTRL_OFS, 32'h1); take(12'h100);
        rd(OLDPSW_OFS, d); check("old_code", d, 32'h100);
        // Several failures and a repeat while masked give one take
        wr(CTRL_OFS, 32'h0); eifl_far_model_inst.fire('0, 16'h0c00);
        repeat (6) @(posedge clk_i);
        eifl_far_model_inst.fire('0, 16'h0400); repeat (6) @(posedge clk_i);
        take(12'h000);
        wr(CTRL_OFS, 32'h1); take(12'h800);
        take(12'h000);
        rd(FRR_OFS, d); check("frr", d, 32'h0c00);
        rd(FRR_OFS, d); check("frr_clr", d, 32'h0);
        // Pair masking: even mask bit covers both bits, odd mask bit unused
        wr(FRM_OFS, 32'h1); eifl_far_model_inst.fire('0, 16'h2);
        repeat (6) @(posedge clk_i);
        take(12'h800);
        rd(FRR_OFS, d); check("frr_pair", d, 32'h2);
        wr(FRM_OFS, 32'h2); eifl_far_model_inst.fire('0, 16'h1);
        repeat (6) @(posedge clk_i);
        take(12'h000);
        rd(FRR_OFS, d); check("frr_unmasked", d, 32'h1);
        // Element check from CE0 forced past both masks only when configured
        wr(FRM_OFS, 32'h0);
        for (int k = 0; k < 4; k++) begin
            wr(CONFIG_OFS, 32'(fc_cfg[k])); wr(CTRL_OFS, 32'(fc_ctrl[k]));
            eifl_far_model_inst.fire('0, 16'h0040); repeat (6) @(posedge clk_i);
            take(fc_code[k]);
            rd(FRR_OFS, d); check("frr_elc", d, 32'h40);
        end
        // Level source keeps re-setting after each read
        eifl_far_model_inst.hold_fail(15, 1'b1); repeat (6) @(posedge clk_i);
        rd(FRR_OFS, d); check("lvl1", d, 32'h8000);
        repeat (2) @(posedge clk_i);
        rd(FRR_OFS, d); check("lvl2", d, 32'h8000);
        eifl_far_model_inst.hold_fail(15, 1'b0); repeat (6) @(posedge clk_i);
        rd(FRR_OFS, d); rd(FRR_OFS, d); check("lvl_gone", d, 32'h0);
        // Forced check under a closed mask leaves the normal request pending
        wr(CONFIG_OFS, 32'h100); wr(CTRL_OFS, 32'h4);
        eifl_far_model_inst.fire(13'h100, 16'h0040); repeat (6) @(posedge clk_i);
        take(12'h800);
        wr(CTRL_OFS, 32'h5); take(12'h100);
        rd(FRR_OFS, d); check("frr_forced", d, 32'h40);
        // Reset in mid-run drops everything still pending
        wr(CTRL_OFS, 32'h0); eifl_far_model_inst.fire(13'h200, 16'h0800); repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b0; repeat (2) @(posedge clk_i);
        #1 check("rst2_out", 32'({ext_int_take_o, old_psw_code_o}), 32'h0);
        reset_n_i <= 1'b1;
        rd(PEND_OFS, d); check("rst2_pend", d, 32'h0);
        rd(FRR_OFS, d); check("rst2_frr", d, 32'h0);
        wr(CTRL_OFS, 32'h1); take(12'h000);
        give_verdict();
    end
endmodule : eifl_top_tb_top
